// ### src/bss_pkg.sv
package bss_pkg;

    // Register byte offsets on the APB bus.
    localparam logic [11:0] ADDR_CTRL   = 12'h000;
    localparam logic [11:0] ADDR_STATUS = 12'h004;
    localparam logic [11:0] ADDR_CLEAR  = 12'h008;
    localparam logic [11:0] ADDR_IRQEN  = 12'h00C;

    // Control register layout and reset value.
    localparam int          CTRL_POLICY_LSB = 0;
    localparam int          CTRL_POLICY_W   = 3;
    localparam logic [2:0]  POLICY_RESET    = 3'h0;

    // Policy code boundaries.
    localparam logic [2:0]  POLICY_DIRECT_MIN  = 3'h3;
    localparam logic [2:0]  POLICY_DISABLE_MIN = 3'h6;

    // Policy codes that keep the low-cell detector running.
    localparam logic [2:0]  POLICY_LOWDET_A = 3'h0;
    localparam logic [2:0]  POLICY_LOWDET_B = 3'h3;

    // Policy codes that switch the power-fail comparator off.
    localparam logic [2:0]  POLICY_PFOFF_A = 3'h2;
    localparam logic [2:0]  POLICY_PFOFF_B = 3'h5;
    localparam logic [2:0]  POLICY_PFOFF_C = 3'h7;

    // Status, clear and enable share one layout.
    localparam int          ST_SWITCH_BIT  = 0;
    localparam int          ST_LOWCELL_BIT = 1;
    localparam int          ST_BACKUP_BIT  = 2;
    localparam int          ST_WARN_BIT    = 3;
    localparam logic [1:0]  IRQEN_RESET    = 2'h0;

    // Recovery hold-off after return to main supply.
    localparam real         TREC_MIN_MS  = 15.63;
    localparam real         TREC_MAX_MS  = 31.25;
    localparam real         CLK_MHZ      = 250.0;
    localparam int          TREC_CYCLES  = $rtoi(TREC_MIN_MS * 1000.0 * CLK_MHZ);
    localparam int          TREC_CNT_W   = 23;

    // Synchroniser width: one bit per comparator result.
    localparam int          CMP_W = 5;

    // Comparator results from the analog front end.
    typedef struct packed {
        logic main_lt_cell;
        logic main_eq_cell;
        logic main_lt_sw;
        logic cell_low;
        logic sense_lt_ref;
    } bss_cmp_type;

    // Power-fail warning sequencer states.
    typedef enum logic [1:0] {
        PF_MONITOR,
        PF_BACKUP,
        PF_RECOVER
    } bss_pf_state_type;

endpackage : bss_pkg

// ### src/bss_rec_timer.sv
`timescale 1ns/1ps
module bss_rec_timer
    import bss_pkg::*;
#(
    parameter int CYCLES = TREC_CYCLES
) (
    input  wire logic core_clk_i,
    input  wire logic nrst_i,
    input  wire logic start_i,
    input  wire logic abort_i,
    output logic      done_o
);
    localparam logic [TREC_CNT_W-1:0] LAST = TREC_CNT_W'(CYCLES - 1);

    logic [TREC_CNT_W-1:0] cnt_r;
    logic                  run_r;

    // Counts CYCLES clocks from start and then pulses done for one cycle.
    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
            cnt_r  <= '0;
            run_r  <= 1'b0;
            done_o <= 1'b0;
        end else begin
            done_o <= 1'b0;
            if (abort_i) begin
                run_r <= 1'b0;
            end else if (start_i) begin
                run_r <= 1'b1;
                cnt_r <= '0;
            end else if (run_r) begin
                if (cnt_r == LAST) begin
                    run_r  <= 1'b0;
                    done_o <= 1'b1;
                end else begin
                    cnt_r <= cnt_r + TREC_CNT_W'(1);
                end
            end
        end
    end
endmodule : bss_rec_timer

// ### src/bss_sync.sv
`timescale 1ns/1ps
module bss_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             core_clk_i,
    input  wire logic             nrst_i,
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] meta_r;

    // Two stages; only the second stage is visible to logic.
    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
            meta_r <= '0;
            sync_o <= '0;
        end else begin
            meta_r <= async_i;
            sync_o <= meta_r;
        end
    end
endmodule : bss_sync

// ### src/bss_top.sv
`timescale 1ns/1ps
// Operation
// - Standard: backup only below cell and threshold.
// - Direct: choose by main-versus-cell comparison only.
// - Disabled: main supply, switch flag held zero.
// - Low cell comparator sets low-cell flag.
// - Cell level watched while on backup.
// - Low-cell interrupt only when enabled.
// - Software cannot clear the low-cell flag.
// - Low-cell flag clears once cell is fine.
// - Sense below reference pulls warning low.
// - Warning pin only pulled low or released.
// - On backup: comparator off, warning low.
// - Back on main: release, hold-off, re-enable.
// - Switch-over off: warning follows comparator only.
// - Three-bit policy field selects mode, detectors.
// - Switch to backup sets flag; command clears.
// - On backup, host interface ignored and released.
module bss_top
    import bss_pkg::*;
#(
    parameter int REC_CYCLES = TREC_CYCLES
) (
    input  wire logic        core_clk_i,
    input  wire logic        nrst_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [11:0] paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    input  bss_pkg::bss_cmp_type cmp_i,
    output logic             backed_supply_out_o,
    output logic             fail_warn_output_n_o,
    output logic             fail_warn_oe_n_o,
    output logic             host_if_oe_n_o,
    output logic             irq_o
);
    import bss_pkg::*;

    bss_cmp_type      cmp_s;
    logic [CMP_W-1:0] cmp_sync;
    logic [2:0]       supply_policy_select_r;
    logic [1:0]       irq_en_r;
    logic             on_backup_r;
    logic             on_backup_nxt;
    logic             supply_switch_flag_r;
    logic             low_cell_flag_r;
    logic             mode_direct;
    logic             mode_disabled;
    logic             lowdet_en;
    logic             pf_en;
    logic             acc;
    logic             wr_en;
    logic             clr_switch;
    logic             went_backup;
    logic             went_main;
    logic             rec_done;
    logic             warn_low_nxt;
    logic             addr_ok;
    logic [31:0]      rd_mux;
    bss_pf_state_type pf_state_r;

    bss_sync #(
        .WIDTH (CMP_W)
    ) u_sync (
        .core_clk_i (core_clk_i),
        .nrst_i     (nrst_i),
        .async_i    (cmp_i),
        .sync_o     (cmp_sync)
    );

    assign cmp_s = bss_cmp_type'(cmp_sync);

    assign mode_disabled = (supply_policy_select_r >= POLICY_DISABLE_MIN);
    assign mode_direct   = (supply_policy_select_r >= POLICY_DIRECT_MIN) && !mode_disabled;
    assign lowdet_en     = (supply_policy_select_r == POLICY_LOWDET_A) ||
                           (supply_policy_select_r == POLICY_LOWDET_B);
    assign pf_en         = !((supply_policy_select_r == POLICY_PFOFF_A) ||
                             (supply_policy_select_r == POLICY_PFOFF_B) ||
                             (supply_policy_select_r == POLICY_PFOFF_C));

    // Supply selection. The equal case holds the present choice, which
    // stops the switch chattering when both supplies sit close together.
    always_comb begin
        on_backup_nxt = on_backup_r;
        if (mode_disabled) begin
            on_backup_nxt = 1'b0;
        end else if (cmp_s.main_eq_cell) begin
            on_backup_nxt = on_backup_r;
        end else if (mode_direct) begin
            on_backup_nxt = cmp_s.main_lt_cell;
        end else begin
            on_backup_nxt = cmp_s.main_lt_cell && cmp_s.main_lt_sw;
        end
    end

    // Selected supply register.
    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
            on_backup_r <= 1'b0;
        end else begin
            on_backup_r <= on_backup_nxt;
        end
    end

    assign went_backup = on_backup_nxt && !on_backup_r;
    assign went_main   = !on_backup_nxt && on_backup_r;

    // APB handshake. One wait state gives the read mux a full cycle.
    // host access ignored on backup
    assign acc        = psel_i && penable_i && !pready_o;
    assign wr_en      = psel_i && penable_i && pready_o && pwrite_i && !on_backup_r;
    assign addr_ok    = (paddr_i == ADDR_CTRL) || (paddr_i == ADDR_STATUS) ||
                        (paddr_i == ADDR_CLEAR) || (paddr_i == ADDR_IRQEN);
    assign clr_switch = wr_en && (paddr_i == ADDR_CLEAR) && pwdata_i[ST_SWITCH_BIT];

    // Read mux; the clear register reads back as zero.
    always_comb begin
        rd_mux = 32'h0000_0000;
        case (paddr_i)
            ADDR_CTRL: begin
                rd_mux[CTRL_POLICY_LSB +: CTRL_POLICY_W] = supply_policy_select_r;
            end
            ADDR_STATUS: begin
                rd_mux[ST_SWITCH_BIT]  = supply_switch_flag_r;
                rd_mux[ST_LOWCELL_BIT] = low_cell_flag_r;
                rd_mux[ST_BACKUP_BIT]  = on_backup_r;
                rd_mux[ST_WARN_BIT]    = !fail_warn_oe_n_o;
            end
            ADDR_IRQEN: begin
                rd_mux[ST_SWITCH_BIT +: 2] = irq_en_r;
            end
            default: begin
                rd_mux = 32'h0000_0000;
            end
        endcase
    end

    // Bus answer registers.
    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
            pready_o  <= 1'b0;
            prdata_o  <= 32'h0000_0000;
            pslverr_o <= 1'b0;
        end else begin
            pready_o  <= acc;
            pslverr_o <= acc && !addr_ok;
            if (acc && !pwrite_i && !on_backup_r) begin
                prdata_o <= rd_mux;
            end else if (acc) begin
                prdata_o <= 32'h0000_0000;
            end
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
            host_if_oe_n_o <= 1'b0;
        end else begin
            host_if_oe_n_o <= on_backup_nxt;
        end
    end

    // Control and enable registers.
    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
            supply_policy_select_r <= POLICY_RESET;
            irq_en_r               <= IRQEN_RESET;
        end else if (wr_en) begin
            if (paddr_i == ADDR_CTRL) begin
                supply_policy_select_r <= pwdata_i[CTRL_POLICY_LSB +: CTRL_POLICY_W];
            end
            if (paddr_i == ADDR_IRQEN) begin
                irq_en_r <= pwdata_i[ST_SWITCH_BIT +: 2];
            end
        end
    end

    // Supply-switch flag. A switch in the same cycle as the clear wins.
    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
            supply_switch_flag_r <= 1'b0;
        end else if (mode_disabled) begin
            supply_switch_flag_r <= 1'b0;
        end else if (went_backup) begin
            supply_switch_flag_r <= 1'b1;
        end else if (clr_switch) begin
            supply_switch_flag_r <= 1'b0;
        end
    end

    // Low-cell flag follows the detector and has no clear path from
    // software; it only drops when the detector stops reporting low.
    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
            low_cell_flag_r <= 1'b0;
        end else if (lowdet_en && cmp_s.cell_low) begin
            low_cell_flag_r <= 1'b1;
        end else begin
            low_cell_flag_r <= 1'b0;
        end
    end

    // Interrupt level output.
    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= (supply_switch_flag_r && irq_en_r[ST_SWITCH_BIT]) ||
                     (low_cell_flag_r && irq_en_r[ST_LOWCELL_BIT]);
        end
    end

    bss_rec_timer #(
        .CYCLES (REC_CYCLES)
    ) u_rec (
        .core_clk_i (core_clk_i),
        .nrst_i     (nrst_i),
        .start_i    (went_main),
        .abort_i    (went_backup),
        .done_o     (rec_done)
    );

    // Warning sequencer. Backup overrides everything else.
    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
            pf_state_r <= PF_MONITOR;
        end else begin
            case (pf_state_r)
                PF_MONITOR: begin
                    if (went_backup) begin
                        pf_state_r <= PF_BACKUP;
                    end
                end
                PF_BACKUP: begin
                    if (went_main) begin
                        pf_state_r <= PF_RECOVER;
                    end
                end
                PF_RECOVER: begin
                    if (went_backup) begin
                        pf_state_r <= PF_BACKUP;
                    end else if (rec_done) begin
                        pf_state_r <= PF_MONITOR;
                    end
                end
                default: begin
                    pf_state_r <= PF_MONITOR;
                end
            endcase
        end
    end

    // Next level of the warning pull-down.
    always_comb begin
        warn_low_nxt = 1'b0;
        case (pf_state_r)
            PF_MONITOR: begin
                warn_low_nxt = pf_en && cmp_s.sense_lt_ref && !went_backup;
                if (went_backup) begin
                    warn_low_nxt = 1'b1;
                end
            end
            PF_BACKUP: begin
                warn_low_nxt = !went_main;
            end
            PF_RECOVER: begin
                warn_low_nxt = went_backup;
            end
            default: begin
                warn_low_nxt = 1'b0;
            end
        endcase
    end

    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
            fail_warn_output_n_o <= 1'b0;
            fail_warn_oe_n_o     <= 1'b1;
        end else begin
            fail_warn_output_n_o <= 1'b0;
            fail_warn_oe_n_o     <= !warn_low_nxt;
        end
    end

    // Supply indicator for the backed output switch.
    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
            backed_supply_out_o <= 1'b0;
        end else begin
            backed_supply_out_o <= on_backup_nxt;
        end
    end

endmodule : bss_top

// ### test/bss_far_model.sv
`timescale 1ns/1ps
module bss_far_model
    import bss_pkg::*;
(
    input  wire logic           core_clk_i,
    input  bss_pkg::bss_cmp_type req_i,
    input  wire logic           fail_warn_oe_n_i,
    input  wire logic           fail_warn_output_n_i,
    output bss_pkg::bss_cmp_type cmp_o,
    output logic                warn_pin_o
);
    import bss_pkg::*;

    // The analog levels settle one cycle late, so the design never sees them on the edge.
    always_ff @(posedge core_clk_i) begin
        cmp_o <= req_i;
    end

    assign warn_pin_o = fail_warn_oe_n_i ? 1'b1 : fail_warn_output_n_i;
endmodule : bss_far_model

// ### test/bss_top_properties.sv
`timescale 1ns/1ps
module bss_props
    import bss_pkg::*;
#(
    parameter int REC_CYCLES = TREC_CYCLES
) (
    input wire logic        core_clk_i,
    input wire logic        nrst_i,
    input wire logic        psel_i,
    input wire logic        penable_i,
    input wire logic        pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [31:0] prdata_o,
    input wire logic        pready_o,
    input wire logic        pslverr_o,
    input bss_pkg::bss_cmp_type cmp_i,
    input wire logic        backed_supply_out_o,
    input wire logic        fail_warn_output_n_o,
    input wire logic        fail_warn_oe_n_o,
    input wire logic        host_if_oe_n_o,
    input wire logic        irq_o
);
    import bss_pkg::*;
    logic [2:0] pol_r;

    // Shadow of the policy field; writes made on backup are refused, so they are skipped.
    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
            pol_r <= POLICY_RESET;
        end else if (psel_i && penable_i && pready_o && pwrite_i && !backed_supply_out_o
                     && paddr_i == ADDR_CTRL) begin
            pol_r <= pwdata_i[2:0];
        end
    end

    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!nrst_i);

    // The policy must have settled through the three-stage comparator path.
    sequence s_pol_steady;
        $stable(pol_r) && pol_r == $past(pol_r, 2);
    endsequence
    sequence s_released;
        (fail_warn_oe_n_o || backed_supply_out_o) [*8];
    endsequence

    a_apb_answer: assert property (psel_i && penable_i && !pready_o |=> pready_o)
        else $error("no answer one cycle after access");
    a_ready_pulse: assert property (pready_o |=> !pready_o)
        else $error("ready held beyond one cycle");
    a_warn_on_backup: assert property (backed_supply_out_o |-> !fail_warn_oe_n_o)
        else $error("warning released while on backup");
    a_warn_drive_low: assert property (!fail_warn_oe_n_o |-> !fail_warn_output_n_o)
        else $error("warning pin driven high");
    a_host_released: assert property (host_if_oe_n_o == backed_supply_out_o)
        else $error("host interface release differs from backup");
    a_recovery_hold: assert property (REC_CYCLES >= 8 && $fell(backed_supply_out_o) |-> s_released)
        else $error("warning not released during hold-off");
    a_disabled_main: assert property (pol_r >= POLICY_DISABLE_MIN |-> !backed_supply_out_o)
        else $error("backup selected with switch-over disabled");
    a_standard_select: assert property (s_pol_steady ##0 (pol_r < POLICY_DIRECT_MIN
        && !$past(cmp_i.main_eq_cell, 3)) |-> backed_supply_out_o ==
        ($past(cmp_i.main_lt_cell, 3) && $past(cmp_i.main_lt_sw, 3)))
        else $error("standard selection wrong");
    a_direct_select: assert property (s_pol_steady ##0 (pol_r >= POLICY_DIRECT_MIN
        && pol_r < POLICY_DISABLE_MIN && !$past(cmp_i.main_eq_cell, 3))
        |-> backed_supply_out_o == $past(cmp_i.main_lt_cell, 3))
        else $error("direct selection wrong");
    a_equal_holds: assert property ($past(cmp_i.main_eq_cell, 3) |-> $stable(backed_supply_out_o))
        else $error("selection changed on equal report");
    a_disabled_warn: assert property (s_pol_steady ##0 pol_r >= POLICY_DISABLE_MIN
        |-> fail_warn_oe_n_o == !(pol_r != POLICY_PFOFF_C && $past(cmp_i.sense_lt_ref, 3)))
        else $error("warning does not follow comparator");
endmodule : bss_props

bind bss_top bss_props #(.REC_CYCLES(REC_CYCLES)) i_props (
    .core_clk_i(core_clk_i), .nrst_i(nrst_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .cmp_i(cmp_i),
    .backed_supply_out_o(backed_supply_out_o), .fail_warn_output_n_o(fail_warn_output_n_o),
    .fail_warn_oe_n_o(fail_warn_oe_n_o), .host_if_oe_n_o(host_if_oe_n_o), .irq_o(irq_o)
);

// ### test/testbench.sv
`timescale 1ns/1ps
module testbench;
    import bss_pkg::*;
    localparam int REC = 20;
    logic        core_clk_i = 1'b0;
    logic        nrst_i     = 1'b0;
    logic        psel_i     = 1'b0;
    logic        penable_i  = 1'b0;
    logic        pwrite_i   = 1'b0;
    logic [11:0] paddr_i    = 12'h000;
    logic [31:0] pwdata_i   = 32'h0;
    logic [31:0] prdata_o;
    logic        pready_o, pslverr_o, backed_supply_out_o, fail_warn_output_n_o;
    logic        fail_warn_oe_n_o, host_if_oe_n_o, irq_o, warn_pin, err;
    bss_cmp_type cmp_req = '0;
    bss_cmp_type cmp_i;
    logic [31:0] rdata;
    int          n_errors  = 0;
    int          cmp_count = 0;
    int          exp_b     = 0;
    int          pols[3]   = '{0, 3, 6};

    always #2 core_clk_i = ~core_clk_i;

    bss_top #(.REC_CYCLES(REC)) i_dut (
        .core_clk_i(core_clk_i), .nrst_i(nrst_i), .psel_i(psel_i), .penable_i(penable_i),
        .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
        .pready_o(pready_o), .pslverr_o(pslverr_o), .cmp_i(cmp_i),
        .backed_supply_out_o(backed_supply_out_o), .fail_warn_output_n_o(fail_warn_output_n_o),
        .fail_warn_oe_n_o(fail_warn_oe_n_o), .host_if_oe_n_o(host_if_oe_n_o), .irq_o(irq_o));
    bss_far_model i_far (.core_clk_i(core_clk_i), .req_i(cmp_req), .cmp_o(cmp_i),
        .fail_warn_oe_n_i(fail_warn_oe_n_o), .fail_warn_output_n_i(fail_warn_output_n_o),
        .warn_pin_o(warn_pin));

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic conclude();
        $display("compares %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : conclude

    task automatic wt(input int n);
        repeat (n) @(posedge core_clk_i);
    endtask : wt

    // One APB transfer; an idle edge follows so a next call never re-drives in the same step.
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel_i   <= 1'b1;
        pwrite_i <= wr;
        paddr_i  <= a;
        pwdata_i <= d;
        @(posedge core_clk_i);
        penable_i <= 1'b1;
        do begin
            @(posedge core_clk_i);
            n++;
        end while (pready_o !== 1'b1 && n < 40);
        rdata = prdata_o;
        err   = pslverr_o;
        psel_i    <= 1'b0;
        penable_i <= 1'b0;
        @(posedge core_clk_i);
        if (n >= 40) begin
            n_errors++;
            conclude();
        end
    endtask : apb

    task automatic rd(input logic [11:0] a, input logic [31:0] exp, input string nm);
        apb(1'b0, a, 32'h0);
        chk(nm, rdata, exp);
    endtask : rd

    // Selection model; an equal report keeps whatever was chosen before.
    function automatic int model_sel(input int pol, input bss_cmp_type c, input int prev);
        if (pol >= 6) return 0;
        if (c.main_eq_cell) return prev;
        if (pol >= 3) return int'(c.main_lt_cell);
        return int'(c.main_lt_cell & c.main_lt_sw);
    endfunction : model_sel

    initial begin
        int sw;
        void'($urandom(32'hdf98a74e));
        wt(20);
        nrst_i <= 1'b1;
        wt(1);
        rd(ADDR_CTRL, 32'h0, "ctrl reset");
        rd(ADDR_IRQEN, 32'h0, "irqen reset");
        rd(ADDR_STATUS, 32'h0, "status reset");
        apb(1'b0, 12'h010, 32'h0);
        chk("unmapped err", 32'(err), 32'h1);
        for (int p = 7; p >= 0; p--) begin
            apb(1'b1, ADDR_CTRL, 32'(p));
            rd(ADDR_CTRL, 32'(p), "ctrl code");
        end
        $display("test registers done");
        foreach (pols[i]) begin
            apb(1'b1, ADDR_CTRL, 32'(pols[i]));
            sw = 0;
            repeat (12) begin
                cmp_req <= bss_cmp_type'(5'($urandom()) & 5'h1C);
                wt(7);
                if (model_sel(pols[i], cmp_req, exp_b) > exp_b) sw = 1;
                exp_b = model_sel(pols[i], cmp_req, exp_b);
                chk("backed", 32'(backed_supply_out_o), 32'(exp_b));
                chk("host release", 32'(host_if_oe_n_o), 32'(exp_b));
            end
            cmp_req <= '0;
            wt(REC + 10);
            exp_b = 0;
            rd(ADDR_STATUS, 32'(sw), "switch flag");
            apb(1'b1, ADDR_CLEAR, 32'h1);
        end
        $display("test selection done");
        apb(1'b1, ADDR_CTRL, 32'h0);
        cmp_req <= bss_cmp_type'(5'h01);
        wt(7);
        chk("warn sense", 32'(warn_pin), 32'h0);
        cmp_req <= bss_cmp_type'(5'h15);
        wt(7);
        chk("warn backup", 32'(warn_pin), 32'h0);
        apb(1'b1, ADDR_IRQEN, 32'h3);
        rd(ADDR_IRQEN, 32'h0, "read on backup");
        cmp_req <= bss_cmp_type'(5'h01);
        wt(13);
        chk("warn hold-off", 32'(warn_pin), 32'h1);
        wt(REC + 8);
        chk("warn resumed", 32'(warn_pin), 32'h0);
        cmp_req <= '0;
        wt(7);
        chk("warn idle", 32'(warn_pin), 32'h1);
        rd(ADDR_IRQEN, 32'h0, "write on backup");
        // The interrupt output is registered one edge after the flag or enable changes.
        apb(1'b1, ADDR_IRQEN, 32'h1);
        wt(1);
        chk("irq switch", 32'(irq_o), 32'h1);
        apb(1'b1, ADDR_CLEAR, 32'h1);
        wt(1);
        chk("irq cleared", 32'(irq_o), 32'h0);
        for (int p = 6; p < 8; p++) begin
            apb(1'b1, ADDR_CTRL, 32'(p));
            cmp_req <= bss_cmp_type'(5'h01);
            wt(7);
            chk("warn disabled", 32'(warn_pin), 32'(p == 7));
            cmp_req <= '0;
            wt(7);
        end
        $display("test warning done");
        apb(1'b1, ADDR_CTRL, 32'h0);
        apb(1'b1, ADDR_IRQEN, 32'h2);
        cmp_req <= bss_cmp_type'(5'h02);
        wt(7);
        chk("irq low cell", 32'(irq_o), 32'h1);
        // Go to backup with a good cell, then let the cell sag while still on backup.
        cmp_req <= bss_cmp_type'(5'h14);
        wt(7);
        chk("backed low test", 32'(backed_supply_out_o), 32'h1);
        chk("irq cell fine", 32'(irq_o), 32'h0);
        cmp_req <= bss_cmp_type'(5'h16);
        wt(7);
        chk("irq low on backup", 32'(irq_o), 32'h1);
        cmp_req <= bss_cmp_type'(5'h02);
        wt(7);
        apb(1'b1, ADDR_CLEAR, 32'h3);
        rd(ADDR_STATUS, 32'h2, "low flag kept");
        apb(1'b1, ADDR_IRQEN, 32'h0);
        wt(1);
        chk("irq masked", 32'(irq_o), 32'h0);
        cmp_req <= '0;
        wt(7);
        rd(ADDR_STATUS, 32'h0, "low flag gone");
        apb(1'b1, ADDR_CTRL, 32'h1);
        cmp_req <= bss_cmp_type'(5'h02);
        wt(7);
        rd(ADDR_STATUS, 32'h0, "low detect off");
        $display("test low cell done");
        conclude();
    end
endmodule : testbench
